// *** logic/adc_channel_config_regs.sv ***
// Channel configuration register bank with channel 1 phase delay line
//
// What this block does
// (RULE1) Channel 1 auto gain runs only with its enable and config bit 3.
// (RULE2) Channel 1 gain is bits 7..2, 1 dB per code, reset zero.
// (RULE3) Gain codes 43..63 are reserved; host must avoid them.
// (RULE4) A volume code of zero mutes the channel 1 output.
// (RULE5) Nonzero volume codes step 0.5 dB from -100 dB to +27 dB.
// (RULE6) Channel 1 volume resets to c9, which is 0 dB.
// (RULE7) Gain trim is bits 7..4, 0.1 dB steps, resets to 8.
// (RULE8) Phase trim N delays channel 1 by N modulator cycles.
// (RULE9) Phase trim zero, its reset value, adds no delay.
// (RULE10) Channel 2 input register at 41 with its five fields.
// (RULE11) Input source: 0 differential, 1 single-ended, 2 PDM, 3 reserved.
// (RULE12) Reserved bits read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
module adc_channel_config_regs (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output var  logic [7:0] reg_rdata,
	input  wire logic       auto_gain_cfg_bit,
	input  wire logic       mod_tick,
	input  wire logic       ch1_sample_in,
	output var  logic       ch1_sample_out,
	output var  logic       ch1_auto_gain_on,
	output var  logic [5:0] ch1_channel_gain,
	output var  logic       ch1_channel_gain_reserved,
	output var  logic       ch1_mute,
	output var  logic [7:0] ch1_volume_code,
	output var  logic [3:0] ch1_channel_gain_trim,
	output var  logic [7:0] ch1_phase_trim,
	output var  logic [1:0] ch1_input_source,
	output var  logic       ch1_source_reserved,
	output var  logic       ch2_input_kind,
	output var  logic [1:0] ch2_input_source,
	output var  logic       ch2_coupling_sel,
	output var  logic [1:0] ch2_input_impedance,
	output var  logic       ch2_auto_gain_en
);
	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] regs_q [chan_cfg_pkg::NUM_REGS];
	logic [7:0] rd_mux;
	logic [7:0] wr_ptr_q;
	logic       last_in_q;
	logic       vol_written_q;
	logic       trim_written_q;
	delay_mem_if dly ();

	// All checks run on the one clock and sleep through reset
	default clocking cb_chk @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// One writer per register; reserved bits are masked off on the way in
	for (genvar i = 0; i < chan_cfg_pkg::NUM_REGS; i++) begin : g_reg
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				regs_q[i] <= chan_cfg_pkg::REG_RST[i]; // RULE6
			end else if (reg_wr && reg_addr == chan_cfg_pkg::REG_OFS[i]) begin
				regs_q[i] <= reg_wdata & chan_cfg_pkg::REG_MASK[i]; // RULE12
			end
		end
	end

	// Read select; unmapped offsets answer zero
	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < chan_cfg_pkg::NUM_REGS; i++) begin
			if (reg_addr == chan_cfg_pkg::REG_OFS[i]) begin
				rd_mux = regs_q[i]; // RULE10
			end
		end
	end

	// Read data held until the next read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end
	end

	// ****************************************
	// Field outputs
	// ****************************************
	// Plain slices of the register flops
	assign ch1_channel_gain = regs_q[chan_cfg_pkg::IDX_CH1_CHANNEL_GAIN]
		[chan_cfg_pkg::GAIN_LSB +: 6]; // RULE2
	assign ch1_volume_code  = regs_q[chan_cfg_pkg::IDX_CH1_VOL]; // RULE5
	assign ch1_channel_gain_trim    = regs_q[chan_cfg_pkg::IDX_CH1_TRIM]
		[chan_cfg_pkg::TRIM_LSB +: 4]; // RULE7
	assign ch1_phase_trim   = regs_q[chan_cfg_pkg::IDX_CH1_PHASE];
	assign ch1_input_source = regs_q[chan_cfg_pkg::IDX_CH1_INPUT]
		[chan_cfg_pkg::SRC_LSB +: 2]; // RULE11
	assign ch2_input_kind   = regs_q[chan_cfg_pkg::IDX_CH2_INPUT]
		[chan_cfg_pkg::KIND_BIT]; // RULE10
	assign ch2_input_source = regs_q[chan_cfg_pkg::IDX_CH2_INPUT]
		[chan_cfg_pkg::SRC_LSB +: 2];
	assign ch2_coupling_sel = regs_q[chan_cfg_pkg::IDX_CH2_INPUT]
		[chan_cfg_pkg::COUPLING_BIT];
	assign ch2_input_impedance = regs_q[chan_cfg_pkg::IDX_CH2_INPUT]
		[chan_cfg_pkg::IMP_LSB +: 2];
	assign ch2_auto_gain_en = regs_q[chan_cfg_pkg::IDX_CH2_INPUT]
		[chan_cfg_pkg::AGC_EN_BIT];

	// Derived controls, registered so every output leaves a flop
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ch1_auto_gain_on    <= 1'b0;
			ch1_mute            <= 1'b0;
			ch1_channel_gain_reserved   <= 1'b0;
			ch1_source_reserved <= 1'b0;
		end else begin
			ch1_auto_gain_on <= regs_q[chan_cfg_pkg::IDX_CH1_INPUT]
				[chan_cfg_pkg::AGC_EN_BIT] & auto_gain_cfg_bit; // RULE1
			ch1_mute <= ch1_volume_code == chan_cfg_pkg::VOL_MUTE; // RULE4
			// Reserved codes are kept, only flagged for the gain stage
			ch1_channel_gain_reserved <= ch1_channel_gain >
				chan_cfg_pkg::GAIN_CODE_MAX; // RULE3
			ch1_source_reserved <= ch1_input_source ==
				chan_cfg_pkg::SRC_RESERVED; // RULE11
		end
	end

	// ****************************************
	// Phase delay line
	// ****************************************
	// Write pointer advances once per modulator cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q  <= 8'h00;
			last_in_q <= 1'b0;
		end else if (mod_tick) begin
			wr_ptr_q  <= wr_ptr_q + 8'h01;
			last_in_q <= ch1_sample_in;
		end
	end

	// Reading N slots behind; N of zero hits the forwarding path
	assign dly.wr_en   = mod_tick;
	assign dly.wr_addr = wr_ptr_q;
	assign dly.wr_data = ch1_sample_in;
	assign dly.rd_addr = wr_ptr_q - ch1_phase_trim; // RULE8 RULE9
	assign ch1_sample_out = dly.rd_data;

	delay_mem u_mem (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.port     (dly.mem)
	);

	// ****************************************
	// Checks
	// ****************************************
	// Helpers: has software touched volume or trim since reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vol_written_q  <= 1'b0;
			trim_written_q <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == chan_cfg_pkg::OFS_CH1_VOL) begin
				vol_written_q <= 1'b1;
			end
			if (reg_addr == chan_cfg_pkg::OFS_CH1_TRIM) begin
				trim_written_q <= 1'b1;
			end
		end
	end

	sequence s_vol_zero;
		reg_wr && reg_addr == chan_cfg_pkg::OFS_CH1_VOL &&
			reg_wdata == chan_cfg_pkg::VOL_MUTE ##1 !reg_wr;
	endsequence

	// Write, one quiet cycle, then a read of the same register
	sequence s_ch2_write_read;
		reg_wr && reg_addr == chan_cfg_pkg::OFS_CH2_INPUT ##1 !reg_wr
			##1 reg_rd && !reg_wr && reg_addr == chan_cfg_pkg::OFS_CH2_INPUT;
	endsequence

	chk_agc_gate: assert property ( // RULE1
		##1 ch1_auto_gain_on == $past(regs_q[chan_cfg_pkg::IDX_CH1_INPUT][0]
			&& auto_gain_cfg_bit))
		else $error("auto gain gate wrong");

	chk_gain_write: assert property ( // RULE2
		reg_wr && reg_addr == chan_cfg_pkg::OFS_CH1_CHANNEL_GAIN
			|=> ch1_channel_gain == $past(reg_wdata[7:2]))
		else $error("gain field not written");

	// Flag must track the stored code both ways, not only stay low
	chk_gain_reserved: assert property ( // RULE3
		reg_wr && reg_addr == chan_cfg_pkg::OFS_CH1_CHANNEL_GAIN ##1 !reg_wr
			|=> ch1_channel_gain_reserved ==
			(ch1_channel_gain > chan_cfg_pkg::GAIN_CODE_MAX))
		else $error("gain reserved flag wrong");

	// Mute is a registered flag, one edge behind the volume field
	chk_mute_zero: assert property ( // RULE4
		s_vol_zero |=> ch1_mute)
		else $error("zero volume did not mute");

	chk_vol_reset: assert property ( // RULE6
		!vol_written_q |-> ch1_volume_code == chan_cfg_pkg::VOL_RST
			&& !ch1_mute)
		else $error("volume reset value lost");

	chk_trim_reset: assert property ( // RULE7
		!trim_written_q |-> ch1_channel_gain_trim == chan_cfg_pkg::TRIM_RST)
		else $error("gain trim reset value lost");

	chk_delay_one: assert property ( // RULE8
		mod_tick && ch1_phase_trim == 8'h01
			|=> ch1_sample_out == $past(last_in_q))
		else $error("one cycle delay wrong");

	chk_delay_bypass: assert property ( // RULE9
		mod_tick && ch1_phase_trim == 8'h00
			|=> ch1_sample_out == $past(ch1_sample_in))
		else $error("zero trim added delay");

	chk_ch2_readback: assert property ( // RULE10
		s_ch2_write_read |=> reg_rdata == ($past(reg_wdata, 3) & 8'hfd))
		else $error("channel 2 readback wrong");

	chk_reserved_zero: assert property ( // RULE12
		reg_rd && reg_addr == chan_cfg_pkg::OFS_CH1_TRIM
			|=> reg_rdata[3:0] == 4'h0)
		else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// *** logic/chan_cfg_pkg.sv ***
// Constants for the channel configuration register bank
package chan_cfg_pkg;

	// ****************************************
	// Register map, indices into the bank
	// ****************************************
	localparam int unsigned NUM_REGS      = 6;
	localparam int unsigned IDX_CH1_INPUT = 0;
	localparam int unsigned IDX_CH1_CHANNEL_GAIN  = 1;
	localparam int unsigned IDX_CH1_VOL   = 2;
	localparam int unsigned IDX_CH1_TRIM  = 3;
	localparam int unsigned IDX_CH1_PHASE = 4;
	localparam int unsigned IDX_CH2_INPUT = 5;

	localparam logic [7:0] OFS_CH1_INPUT = 8'h3c;
	localparam logic [7:0] OFS_CH1_CHANNEL_GAIN  = 8'h3d;
	localparam logic [7:0] OFS_CH1_VOL   = 8'h3e;
	localparam logic [7:0] OFS_CH1_TRIM  = 8'h3f;
	localparam logic [7:0] OFS_CH1_PHASE = 8'h40;
	localparam logic [7:0] OFS_CH2_INPUT = 8'h41;

	localparam logic [7:0] REG_OFS [NUM_REGS] = '{OFS_CH1_INPUT,
		OFS_CH1_CHANNEL_GAIN, OFS_CH1_VOL, OFS_CH1_TRIM, OFS_CH1_PHASE,
		OFS_CH2_INPUT};
	// Writable bits; the rest are reserved
	localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'hfd, 8'hfc, 8'hff,
		8'hf0, 8'hff, 8'hfd};
	localparam logic [7:0] REG_RST [NUM_REGS] = '{8'h00, 8'h00, 8'hc9,
		8'h80, 8'h00, 8'h00};

	// ****************************************
	// Field positions and codes
	// ****************************************
	localparam int unsigned KIND_BIT     = 7;
	localparam int unsigned SRC_LSB      = 5;
	localparam int unsigned COUPLING_BIT = 4;
	localparam int unsigned IMP_LSB      = 2;
	localparam int unsigned AGC_EN_BIT   = 0;
	localparam int unsigned GAIN_LSB     = 2;
	localparam int unsigned TRIM_LSB     = 4;

	localparam logic [5:0] GAIN_CODE_MAX = 6'h2a;
	localparam logic [7:0] VOL_MUTE      = 8'h00;
	localparam logic [7:0] VOL_RST       = 8'hc9;
	localparam logic [3:0] TRIM_RST      = 4'h8;
	localparam int unsigned DELAY_DEPTH  = 256;

	typedef enum logic [1:0] {
		SRC_ANALOG_DIFF   = 2'h0,
		SRC_ANALOG_SINGLE = 2'h1,
		SRC_DIGITAL_PDM   = 2'h2,
		SRC_RESERVED      = 2'h3
	} input_source_e;

endpackage

// *** logic/delay_mem.sv ***
// Sample memory for the phase delay line, registered read
`timescale 1ns/10ps
`default_nettype none
module delay_mem (
	input  wire logic    core_clk,
	input  wire logic    rst_n,
	delay_mem_if.mem     port
);
	logic store [chan_cfg_pkg::DELAY_DEPTH];

	// Array itself carries no reset; its contents are don't-care at start
	always_ff @(posedge core_clk) begin
		if (port.wr_en) begin
			store[port.wr_addr] <= port.wr_data;
		end
	end

	// Read happens with each write; same address forwards the new sample
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port.rd_data <= 1'b0;
		end else if (port.wr_en) begin
			port.rd_data <= (port.rd_addr == port.wr_addr) ?
				port.wr_data : store[port.rd_addr];
		end
	end
endmodule
`default_nettype wire

// *** logic/delay_mem_if.sv ***
// Carrier between the phase delay logic and its sample memory
`timescale 1ns/10ps
`default_nettype none
interface delay_mem_if;
	logic       wr_en;
	logic [7:0] wr_addr;
	logic       wr_data;
	logic [7:0] rd_addr;
	logic       rd_data;

	modport user (output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data);
endinterface
`default_nettype wire

// *** testbench/adc_channel_config_regs_test.sv ***
// Self-checking bench for the channel configuration register bank
`timescale 1ns/10ps
`default_nettype none
module adc_channel_config_regs_test;
	logic        core_clk, rst_n, reg_wr, reg_rd, auto_gain_cfg_bit;
	logic        mod_tick, ch1_sample_in, ch1_sample_out, ch1_auto_gain_on;
	logic        ch1_channel_gain_reserved, ch1_mute, ch1_source_reserved;
	logic        ch2_input_kind, ch2_coupling_sel, ch2_auto_gain_en;
	logic [1:0]  ch1_input_source, ch2_input_source, ch2_input_impedance;
	logic [3:0]  ch1_channel_gain_trim;
	logic [5:0]  ch1_channel_gain;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, ch1_volume_code;
	logic [7:0]  ch1_phase_trim, rv;
	logic [7:0]  mdl [6];
	logic [7:0]  vol [4] = '{8'h00, 8'h01, 8'hff, 8'h00};
	logic        hist [$];
	logic [31:0] seed = 32'he032b057;
	int          errors = 0, cmp_count = 0, idx;

	adc_channel_config_regs DUT (.core_clk, .rst_n, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata, .auto_gain_cfg_bit, .mod_tick,
		.ch1_sample_in, .ch1_sample_out, .ch1_auto_gain_on,
		.ch1_channel_gain, .ch1_channel_gain_reserved, .ch1_mute, .ch1_volume_code,
		.ch1_channel_gain_trim, .ch1_phase_trim, .ch1_input_source,
		.ch1_source_reserved, .ch2_input_kind, .ch2_input_source,
		.ch2_coupling_sel, .ch2_input_impedance, .ch2_auto_gain_en);
	reg_host host (.core_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata);

	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("errors=%0d cmp_count=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Output checked a cycle late; it stands until the next tick anyway
	task automatic tick(input int tr);
		mod_tick = 1'b1;
		ch1_sample_in = ^rnd();
		hist.push_front(ch1_sample_in);
		@(posedge core_clk);
		#1 mod_tick = 1'b0;
		@(posedge core_clk);
		#1 chk({7'h00, ch1_sample_out}, {7'h00, hist[tr]});
	endtask

	task automatic wrm(input int i, input logic [7:0] d);
		host.wr(chan_cfg_pkg::REG_OFS[i], d);
		mdl[i] = d & chan_cfg_pkg::REG_MASK[i];
	endtask

	// Derived flags lag the field by a cycle, so wait two edges
	task automatic fields();
		repeat (2) @(posedge core_clk);
		#1 chk({ch1_channel_gain, ch1_mute, ch1_auto_gain_on},
			{mdl[1][7:2], mdl[2] == 8'h00, mdl[0][0] & auto_gain_cfg_bit});
		chk(ch1_volume_code, mdl[2]);
		chk({ch1_channel_gain_trim, ch1_input_source, ch1_source_reserved,
			ch1_channel_gain_reserved}, {mdl[3][7:4], mdl[0][6:5],
			mdl[0][6:5] == 2'h3, 1'b0});
		chk(ch1_phase_trim, mdl[4]);
		chk({ch2_input_kind, ch2_input_source, ch2_coupling_sel,
			ch2_input_impedance, ch2_auto_gain_en, 1'b0},
			{mdl[5][7:2], mdl[5][0], 1'b0});
	endtask

	// ****************************************
	// Stimulus
	// ****************************************
	initial begin
		rst_n = 1'b0;
		mod_tick = 1'b0;
		ch1_sample_in = 1'b0;
		auto_gain_cfg_bit = 1'b0;
		mdl = chan_cfg_pkg::REG_RST;
		repeat (12) @(posedge core_clk);
		#1 rst_n = 1'b1;
		// Reset values, then an unmapped offset
		for (int i = 0; i < 6; i++) begin
			host.rd(chan_cfg_pkg::REG_OFS[i], rv);
			chk(rv, mdl[i]);
		end
		host.rd(8'h42, rv);
		chk(rv, 8'h00);
		fields();
		// Fill the delay memory first; its contents start undefined
		repeat (260) tick(0);
		wrm(4, 8'h01);
		repeat (40) tick(1);
		wrm(4, 8'h03);
		repeat (40) tick(3);
		wrm(4, 8'hff);
		repeat (40) tick(255);
		// Every source code, both config levels, mute boundaries
		for (int k = 0; k < 4; k++) begin
			auto_gain_cfg_bit = k[0];
			wrm(0, {1'b0, k[1:0], 4'h0, 1'b1});
			wrm(2, vol[k]);
			fields();
		end
		// Random writes, each read back
		repeat (30) begin
			auto_gain_cfg_bit = 1'(rnd() % 2);
			idx = rnd() % 6;
			rv = 8'(rnd());
			if (idx == 1)
				rv[7:2] = 6'(rnd() % 43);
			wrm(idx, rv);
			host.rd(chan_cfg_pkg::REG_OFS[idx], rv);
			chk(rv, mdl[idx]);
			fields();
		end
		test_done();
	end

	// Watchdog far beyond the expected run of about 1000 cycles
	initial begin
		#200000;
		errors++;
		test_done();
	end
endmodule
`default_nettype wire

// *** testbench/reg_host.sv ***
// Host model driving the register strobes of the configuration bank
`timescale 1ns/10ps
`default_nettype none
module reg_host (
	input  wire logic       core_clk,
	input  wire logic [7:0] reg_rdata,
	output var  logic       reg_wr,
	output var  logic       reg_rd,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata
);
	// Idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// One-cycle write; address and data flip once unqualified.
	// An idle edge follows, so a next strobe never rises in the same
	// step that lowers this one.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == chan_cfg_pkg::OFS_CH1_CHANNEL_GAIN && d[7:2] > 6'h2a)
			d[7:2] = 6'h2a;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge core_clk);
		#1 reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
		@(posedge core_clk);
		#1;
	endtask
	// Read data stands until the next read, so one spare edge is safe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge core_clk);
		#1 reg_rd = 1'b0;
		reg_addr = ~a;
		@(posedge core_clk);
		#1 d = reg_rdata;
	endtask
endmodule
`default_nettype wire
